// ### hw/tmr_core.sv
/*
 capture/match timer with prescaler, event counting and apb register file.
 assumes an apb3 master on clk; cap_pin is asynchronous to clk.
*/
// Summary of operation
// R1 - count clock cycles or external events
// R2 - 32-bit counter behind 32-bit prescaler
// R3 - four captures latch count on edges
// R4 - continuous match with optional flag
// R5 - stop-on-match halts the counter
// R6 - reset-on-match clears the counter
// R7 - match outputs low, high, toggle, none
// R8 - event mode counts one capture input
// R9 - other captures trigger or interrupt only
// R10 - pins combined by or/and, outputs broadcast
// R11 - prescale wrap advances counter, clears prescale
// R12 - equal count on a step flags match when its interrupt bit is set; write one clears
module tmr_core (
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [tmr_pkg::CAP_PINS-1:0] cap_pin,
	output logic      [tmr_pkg::CH_N-1:0]     mat_out,
	output logic      [tmr_pkg::MAT_PINS-1:0] mat_pin,
	output logic                           irq
);
	import tmr_pkg::*;

	logic [CAP_PINS-1:0]  s1_q, s1_d, s2_q, s2_d;
	logic [CTRL_W-1:0]    ctrl_q, ctrl_d;
	logic [31:0]          tc_q, tc_d, pc_q, pc_d, pr_q, pr_d;
	logic [11:0]          mc_q, mc_d;
	logic [15:0]          cc_q, cc_d;
	logic [7:0]           act_q, act_d;
	logic [ST_W-1:0]      st_q, st_d, mask_q, mask_d, set_v;
	logic [11:0]          cr_q, cr_d;
	logic [15:0]          mr_rt_q, mr_rt_d;
	logic [31:0]          mr_q [CH_N];
	logic [31:0]          mr_d [CH_N];
	logic [MAT_PINS-1:0]  mp_q, mp_d;
	logic [31:0]          rd_q, rd_d, rd_v;
	logic                 rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
	logic [CH_N-1:0]      rise_v, fall_v, cflag_v, hit_v, mflag_v, lvl_v, lv_v;
	logic [CH_N-1:0]      rst_v, stop_v;
	logic [31:0]          cap_v [CH_N];
	logic                 acc, wr, mapped, tick, step, evt_edge, any_rst, any_stop;
	logic [1:0]           src;

	tmr_cap_if cap [CH_N] ();
	tmr_mch_if mch [CH_N] ();

	assign src = ctrl_q[CTRL_SRC +: 2];

	for (genvar c = 0; c < CH_N; c++) begin : g_ch
		logic a, b, ea, eb, andm;
		assign a = s2_q[2*c];
		assign b = s2_q[2*c+1];
		assign ea = cr_q[c*CR_W+CR_A];
		assign eb = cr_q[c*CR_W+CR_B];
		assign andm = cr_q[c*CR_W+CR_AND];
		// and needs at least one routed pin; unrouted pins are neutral
		assign lv_v[c] = andm ? ((a | ~ea) & (b | ~eb) & (ea | eb)) : ((a & ea) | (b & eb)); // see R10
		assign cap[c].level = lv_v[c];
		assign cap[c].cfg = cc_q[c*CC_W +: CC_W];
		assign cap[c].inhibit = ctrl_q[CTRL_EVT] && (src == 2'(c)); // see R9
		assign cap[c].count = tc_q;
		assign rise_v[c] = cap[c].rise;
		assign fall_v[c] = cap[c].fall;
		assign cflag_v[c] = cap[c].flag;
		assign cap_v[c] = cap[c].value;
		tmr_capture u_cap (.clk(clk), .sys_rst(sys_rst), .cp(cap[c]));

		assign mch[c].count = tc_q;
		assign mch[c].match_val = mr_q[c];
		assign mch[c].step = step;
		assign mch[c].cfg = mc_q[c*MC_W +: MC_W];
		assign mch[c].act = tmr_act_t'(act_q[2*c +: 2]);
		assign mch[c].preset_we = wr && paddr == OFS_EXTC;
		assign mch[c].preset_val = pwdata[EX_LVL+c];
		assign hit_v[c] = mch[c].hit;
		assign mflag_v[c] = mch[c].flag;
		assign lvl_v[c] = mch[c].level;
		assign rst_v[c] = mch[c].hit & mc_q[c*MC_W+MC_RST]; // see R6
		assign stop_v[c] = mch[c].hit & mc_q[c*MC_W+MC_STOP]; // see R5
		tmr_match u_mch (.clk(clk), .sys_rst(sys_rst), .mp(mch[c]));

		chk_route_and: // see R10
		assert property (@(posedge clk) disable iff (sys_rst) lv_v[c] && andm && ea && eb |-> a && b)
			else $error("and routing passed a low pin");
	end

	assign mat_out = lvl_v;

	// pin synchroniser
	always_comb begin
		s1_d = cap_pin;
		s2_d = s1_q;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	// apb handshake and read mux
	always_comb begin
		acc = psel & penable;
		wr = acc & rdy_q & pwrite;
		rdy_d = acc & ~rdy_q;
		mapped = paddr[1:0] == 2'b00 && (paddr <= OFS_MROUTE || paddr[7:4] == OFS_MR_PAGE
			|| paddr[7:4] == OFS_CR_PAGE);
		err_d = rdy_d & ~mapped;
		rd_v = RST_WORD;
		unique case (paddr)
			OFS_CTRL:   rd_v[CTRL_W-1:0] = ctrl_q;
			OFS_COUNT:  rd_v = tc_q;
			OFS_PRESC:  rd_v = pr_q;
			OFS_PCOUNT: rd_v = pc_q;
			OFS_MCTRL:  rd_v[11:0] = mc_q;
			OFS_CCTRL:  rd_v[15:0] = cc_q;
			OFS_EXTC:   rd_v[11:0] = {lvl_v, act_q};
			OFS_STATUS: rd_v[ST_W-1:0] = st_q;
			OFS_MASK:   rd_v[ST_W-1:0] = mask_q;
			OFS_CROUTE: rd_v[11:0] = cr_q;
			OFS_MROUTE: rd_v[15:0] = mr_rt_q;
			default: begin
				if (paddr[7:4] == OFS_MR_PAGE) begin
					rd_v = mr_q[paddr[3:2]];
				end else if (paddr[7:4] == OFS_CR_PAGE) begin
					rd_v = cap_v[paddr[3:2]];
				end
			end
		endcase
		rd_d = (rdy_d & ~pwrite & mapped) ? rd_v : rd_q;
	end

	// counter, prescaler and registers
	always_comb begin
		any_rst = |rst_v;
		any_stop = |stop_v;
		evt_edge = (rise_v[src] & ctrl_q[CTRL_RISE]) | (fall_v[src] & ctrl_q[CTRL_FALL]); // see R8
		tick = ctrl_q[CTRL_EN] & ~ctrl_q[CTRL_CRST] & (ctrl_q[CTRL_EVT] ? evt_edge : 1'b1); // see R1
		step = tick & (pc_q == pr_q); // see R11
		ctrl_d = ctrl_q;
		if (wr && paddr == OFS_CTRL) begin
			ctrl_d = pwdata[CTRL_W-1:0];
		end else if (any_stop) begin
			ctrl_d[CTRL_EN] = 1'b0; // see R5
		end
		tc_d = tc_q;
		if (wr && paddr == OFS_COUNT) begin
			tc_d = pwdata;
		end else if (ctrl_q[CTRL_CRST]) begin
			tc_d = RST_WORD;
		end else if (step) begin
			tc_d = any_rst ? RST_WORD : tc_q + 32'h0000_0001; // see R2 R4 R6
		end
		pc_d = pc_q;
		if (wr && paddr == OFS_PCOUNT) begin
			pc_d = pwdata;
		end else if (ctrl_q[CTRL_CRST]) begin
			pc_d = RST_WORD;
		end else if (tick) begin
			pc_d = step ? RST_WORD : pc_q + 32'h0000_0001; // see R11
		end
		pr_d = (wr && paddr == OFS_PRESC) ? pwdata : pr_q;
		mc_d = (wr && paddr == OFS_MCTRL) ? pwdata[11:0] : mc_q;
		cc_d = (wr && paddr == OFS_CCTRL) ? pwdata[15:0] : cc_q;
		act_d = (wr && paddr == OFS_EXTC) ? pwdata[7:0] : act_q;
		mask_d = (wr && paddr == OFS_MASK) ? pwdata[ST_W-1:0] : mask_q;
		cr_d = (wr && paddr == OFS_CROUTE) ? pwdata[11:0] : cr_q;
		mr_rt_d = (wr && paddr == OFS_MROUTE) ? pwdata[15:0] : mr_rt_q;
		for (int i = 0; i < CH_N; i++) begin
			mr_d[i] = (wr && paddr[7:4] == OFS_MR_PAGE && paddr[3:2] == 2'(i)) ? pwdata : mr_q[i];
		end
		set_v = {cflag_v, mflag_v};
		// write one clears; a new event in the same cycle wins
		st_d = (st_q & ~((wr && paddr == OFS_STATUS) ? pwdata[ST_W-1:0] : '0)) | set_v; // see R12
		irq_d = |(st_d & mask_d);
		for (int j = 0; j < MAT_PINS; j++) begin
			mp_d[j] = lvl_v[mr_rt_q[2*j +: 2]]; // see R10
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= '0;
			tc_q <= RST_WORD;
			pc_q <= RST_WORD;
			pr_q <= RST_WORD;
			mc_q <= '0;
			cc_q <= '0;
			act_q <= '0;
			st_q <= '0;
			mask_q <= '0;
			cr_q <= '0;
			mr_rt_q <= '0;
			mp_q <= '0;
			rd_q <= RST_WORD;
			rdy_q <= RST_BIT;
			err_q <= RST_BIT;
			irq_q <= RST_BIT;
			for (int i = 0; i < CH_N; i++) begin
				mr_q[i] <= RST_WORD;
			end
		end else begin
			ctrl_q <= ctrl_d;
			tc_q <= tc_d;
			pc_q <= pc_d;
			pr_q <= pr_d;
			mc_q <= mc_d;
			cc_q <= cc_d;
			act_q <= act_d;
			st_q <= st_d;
			mask_q <= mask_d;
			cr_q <= cr_d;
			mr_rt_q <= mr_rt_d;
			mp_q <= mp_d;
			rd_q <= rd_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
			irq_q <= irq_d;
			for (int i = 0; i < CH_N; i++) begin
				mr_q[i] <= mr_d[i];
			end
		end
	end

	assign prdata = rd_q;
	assign pready = rdy_q;
	assign pslverr = err_q;
	assign mat_pin = mp_q;
	assign irq = irq_q;

	default clocking dc @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic quiet;
	assign quiet = !wr && !ctrl_q[CTRL_CRST];

	sequence evt_rise_s;
		quiet && ctrl_q[CTRL_EN] && ctrl_q[CTRL_EVT] && ctrl_q[CTRL_RISE] ##0 $rose(lv_v[src]);
	endsequence

	sequence plain_step_s;
		quiet && step && !any_rst;
	endsequence

	chk_presc_wrap: // see R11
	assert property (quiet && step |=> pc_q == 32'h0000_0000) else $error("prescale not cleared on wrap");
	chk_count_step: // see R2
	assert property (plain_step_s |=> tc_q == $past(tc_q) + 32'h0000_0001) else $error("counter missed a step");
	chk_timer_tick: // see R1
	assert property (quiet && ctrl_q[CTRL_EN] && !ctrl_q[CTRL_EVT] && pc_q != pr_q |=> pc_q == $past(pc_q) + 32'h1)
		else $error("prescale did not follow the clock");
	chk_event_count: // see R8
	assert property (evt_rise_s |=> pc_q == $past(pc_q) + 32'h1 || pc_q == 32'h0) else $error("event not counted");
	chk_stop_halt: // see R5
	assert property (quiet && any_stop |=> !ctrl_q[CTRL_EN] ##1 $stable(tc_q)) else $error("stop match did not halt");
	chk_reset_zero: // see R6
	assert property (quiet && any_rst |=> tc_q == 32'h0000_0000) else $error("reset match did not clear");
	chk_match_flag: // see R12
	assert property (|mflag_v |=> (st_q[CH_N-1:0] & $past(mflag_v)) == $past(mflag_v)) else $error("match flag lost");
	chk_cont_run: // see R4
	assert property (plain_step_s and (|hit_v && !any_stop) |=> ctrl_q[CTRL_EN])
		else $error("continuous match stopped");
	chk_ext_irq: // see R9
	assert property (|cflag_v |=> |(st_q[ST_W-1:ST_CAP] & $past(cflag_v)) ##1 (irq == |(st_q & mask_q)))
		else $error("capture flag or interrupt wrong");
endmodule // tmr_core

// ### hw/tmr_pkg.sv
/*
 package of the capture/match timer: register offsets, field positions,
 reset values and output actions.
 assumes a 32-bit apb slave with byte addresses in paddr[7:0].
*/
package tmr_pkg;
	localparam int unsigned CH_N     = 4;
	localparam int unsigned CAP_PINS = 8;
	localparam int unsigned MAT_PINS = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_COUNT   = 8'h04;
	localparam logic [7:0] OFS_PRESC   = 8'h08;
	localparam logic [7:0] OFS_PCOUNT  = 8'h0C;
	localparam logic [7:0] OFS_MCTRL   = 8'h10;
	localparam logic [7:0] OFS_CCTRL   = 8'h14;
	localparam logic [7:0] OFS_EXTC    = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_MASK    = 8'h20;
	localparam logic [7:0] OFS_CROUTE  = 8'h24;
	localparam logic [7:0] OFS_MROUTE  = 8'h28;
	localparam logic [3:0] OFS_MR_PAGE = 4'h4;
	localparam logic [3:0] OFS_CR_PAGE = 4'h5;

	// control register fields
	localparam int unsigned CTRL_EN   = 0;
	localparam int unsigned CTRL_CRST = 1;
	localparam int unsigned CTRL_EVT  = 2;
	localparam int unsigned CTRL_SRC  = 3;
	localparam int unsigned CTRL_RISE = 5;
	localparam int unsigned CTRL_FALL = 6;
	localparam int unsigned CTRL_W    = 7;

	// match control, three bits per channel
	localparam int unsigned MC_INT  = 0;
	localparam int unsigned MC_RST  = 1;
	localparam int unsigned MC_STOP = 2;
	localparam int unsigned MC_W    = 3;

	// capture control, four bits per channel
	localparam int unsigned CC_RISE  = 0;
	localparam int unsigned CC_FALL  = 1;
	localparam int unsigned CC_INT   = 2;
	localparam int unsigned CC_LATCH = 3;
	localparam int unsigned CC_W     = 4;

	// capture routing, three bits per channel
	localparam int unsigned CR_A   = 0;
	localparam int unsigned CR_B   = 1;
	localparam int unsigned CR_AND = 2;
	localparam int unsigned CR_W   = 3;

	// external control: actions then output levels
	localparam int unsigned EX_LVL = 8;
	localparam int unsigned ST_CAP = 4;
	localparam int unsigned ST_W   = 8;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic        RST_BIT  = 1'b0;

	typedef enum logic [1:0] {ACT_NONE, ACT_LOW, ACT_HIGH, ACT_TOGGLE} tmr_act_t;
endpackage

// ### hw/tmr_chan_if.sv
/*
 channel carriers between the timer core and its capture and match channels.
 assumes one instance per channel, driven from the core.
*/
interface tmr_cap_if;
	logic                 level;
	logic [3:0]           cfg;
	logic                 inhibit;
	logic [31:0]          count;
	logic                 rise;
	logic                 fall;
	logic                 flag;
	logic [31:0]          value;
	modport ctl  (output level, cfg, inhibit, count, input rise, fall, flag, value);
	modport chan (input level, cfg, inhibit, count, output rise, fall, flag, value);
endinterface

interface tmr_mch_if;
	logic [31:0]          count;
	logic [31:0]          match_val;
	logic                 step;
	logic [2:0]           cfg;
	tmr_pkg::tmr_act_t    act;
	logic                 preset_we;
	logic                 preset_val;
	logic                 hit;
	logic                 flag;
	logic                 level;
	modport ctl  (output count, match_val, step, cfg, act, preset_we, preset_val, input hit, flag, level);
	modport chan (input count, match_val, step, cfg, act, preset_we, preset_val, output hit, flag, level);
endinterface

// ### hw/tmr_capture.sv
/*
 one capture channel: edge detection, latch of the count, flag pulse.
 assumes level is already synchronised to clk.
*/
module tmr_capture (
	input wire logic       clk,
	input wire logic       sys_rst,
	tmr_cap_if.chan        cp
);
	import tmr_pkg::*;

	logic        prev_q;
	logic        prev_d;
	logic [31:0] val_q;
	logic [31:0] val_d;
	logic        hit;

	always_comb begin
		prev_d = cp.level;
		cp.rise = cp.level & ~prev_q;
		cp.fall = ~cp.level & prev_q;
		hit = ~cp.inhibit & ((cp.rise & cp.cfg[CC_RISE]) | (cp.fall & cp.cfg[CC_FALL])); // see R9
		cp.flag = hit & cp.cfg[CC_INT]; // see R3
		val_d = (hit & cp.cfg[CC_LATCH]) ? cp.count : val_q; // see R3
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_q <= RST_BIT;
			val_q <= RST_WORD;
		end else begin
			prev_q <= prev_d;
			val_q <= val_d;
		end
	end

	assign cp.value = val_q;

	chk_capture_latch: // see R3
	assert property (@(posedge clk) disable iff (sys_rst) hit && cp.cfg[CC_LATCH] |=> cp.value == $past(cp.count))
		else $error("capture did not latch the count");
endmodule // tmr_capture

// ### hw/tmr_match.sv
/*
 one match channel: compare, hit pulse and external output level.
 assumes step marks the cycle in which the counter would advance.
*/
module tmr_match (
	input wire logic       clk,
	input wire logic       sys_rst,
	tmr_mch_if.chan        mp
);
	import tmr_pkg::*;

	logic lvl_q;
	logic lvl_d;

	always_comb begin
		mp.hit = mp.step & (mp.count == mp.match_val); // see R12
		mp.flag = mp.hit & mp.cfg[MC_INT]; // see R4
		lvl_d = lvl_q;
		if (mp.preset_we) begin
			lvl_d = mp.preset_val;
		end else if (mp.hit) begin
			unique case (mp.act) // see R7
				ACT_NONE:   lvl_d = lvl_q;
				ACT_LOW:    lvl_d = 1'b0;
				ACT_HIGH:   lvl_d = 1'b1;
				ACT_TOGGLE: lvl_d = ~lvl_q;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lvl_q <= RST_BIT;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	assign mp.level = lvl_q;

	chk_match_toggle: // see R7
	assert property (@(posedge clk) disable iff (sys_rst)
		mp.hit && !mp.preset_we && mp.act == ACT_TOGGLE |=> mp.level != $past(mp.level))
		else $error("match output did not toggle");
endmodule // tmr_match

// ### testbench/tmr_pin_model.sv
/*
 capture pin source for the timer bench: drives requested pins high for a while.
 assumes req is driven by the bench right after a rising clk edge, one cycle long.
*/
module tmr_pin_model (
	input  wire logic       clk,
	input  wire logic [7:0] req,
	output logic      [7:0] cap_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	int unsigned left;

	initial begin
		cap_pin = 8'h00;
		left    = 0;
	end

	// pulse held four clocks, well over one period
	always @(posedge clk) begin
		if (req != 8'h00) begin
			cap_pin <= req;
			left    <= 4;
		end else if (left > 1) begin
			left <= left - 1;
		end else begin
			cap_pin <= 8'h00;
			left    <= 0;
		end
	end
endmodule // tmr_pin_model

// ### testbench/test_tmr_core.sv
/*
 self-checking bench of the capture/match timer: apb tasks and register tests.
 assumes tmr_core with one wait state per access and the pin model beside it.
*/
module test_tmr_core;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;

	logic        clk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        e;
	logic [7:0]  paddr;
	logic [7:0]  req;
	logic [7:0]  cap_pin;
	logic [7:0]  mat_pin;
	logic [3:0]  mat_out;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] q;
	int          n_errors;
	int          total_checks;

	tmr_core i_tmr_core (
		.clk     (clk),
		.sys_rst (sys_rst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.cap_pin (cap_pin),
		.mat_out (mat_out),
		.mat_pin (mat_pin),
		.irq     (irq)
	);

	tmr_pin_model i_tmr_pin_model (
		.clk     (clk),
		.req     (req),
		.cap_pin (cap_pin)
	);

	always #12.5 clk = ~clk;

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, answer taken at the edge where pready is high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_errors++;
			give_verdict();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			n_errors++;
			give_verdict();
		end
	endtask

	task automatic arm(input logic [31:0] presc, input logic [31:0] mctrl, input logic [31:0] mask);
		wr(OFS_PRESC, presc);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_PCOUNT, 32'h0);
		wr(OFS_STATUS, 32'hFF);
		wr(OFS_MASK, mask);
		wr(OFS_MCTRL, mctrl);
		wr(OFS_CTRL, 32'h1);
		wait_irq();
	endtask

	task automatic pulse(input logic [7:0] m);
		@(posedge clk);
		req <= m;
		@(posedge clk);
		req <= 8'h00;
		repeat (10) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		req = 8'h00;
		n_errors = 0;
		total_checks = 0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, errors, read-only capture
		rd(OFS_CTRL, 32'h0);
		rd(OFS_COUNT, 32'h0);
		rd(OFS_STATUS, 32'h0);
		chk(32'(irq), 32'h0);
		xfer(1'b0, 8'h30, 32'h0);
		chk(32'(e), 32'h1);
		xfer(1'b0, 8'h02, 32'h0);
		chk(32'(e), 32'h1);
		wr(8'h40, 32'hA5A5_5A5A);
		rd(8'h40, 32'hA5A5_5A5A);
		wr(8'h50, 32'h1);
		chk(32'(e), 32'h0);
		rd(8'h50, 32'h0);
		$display("test registers done");
		// stop on match behind prescale of three
		wr(8'h40, 32'h5);
		arm(32'h2, 32'h5, 32'h1);
		rd(OFS_COUNT, 32'h6);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_PCOUNT, 32'h0);
		rd(OFS_STATUS, 32'h1);
		chk(32'(irq), 32'h1);
		wr(OFS_STATUS, 32'h1);
		rd(OFS_STATUS, 32'h0);
		chk(32'(irq), 32'h0);
		$display("test stop done");
		// reset on match, then masking
		wr(8'h44, 32'h3);
		arm(32'h0, 32'h18, 32'h2);
		wr(OFS_CTRL, 32'h0);
		xfer(1'b0, OFS_COUNT, 32'h0);
		chk(32'(q <= 32'h3), 32'h1);
		wr(OFS_MASK, 32'h0);
		rd(OFS_STATUS, 32'h2);
		chk(32'(irq), 32'h0);
		$display("test reset done");
		// continuous match
		wr(8'h48, 32'h4);
		arm(32'h0, 32'h40, 32'h4);
		wr(OFS_CTRL, 32'h0);
		xfer(1'b0, OFS_COUNT, 32'h0);
		chk(32'(q > 32'h4), 32'h1);
		rd(OFS_STATUS, 32'h4);
		$display("test continuous done");
		// output actions none, low, high, toggle and broadcast
		wr(OFS_MROUTE, 32'hE4E4);
		wr(OFS_EXTC, 32'h3E4);
		rd(OFS_EXTC, 32'h3E4);
		chk(32'(mat_out), 32'h3);
		for (int i = 0; i < 4; i++) begin
			wr(8'h40 + 8'(4 * i), 32'h2);
		end
		arm(32'h0, 32'h5, 32'h1);
		rd(OFS_EXTC, 32'hDE4);
		chk(32'(mat_out), 32'hD);
		chk(32'(mat_pin), 32'hDD);
		$display("test outputs done");
		// captures: or, and, interrupt only
		wr(OFS_CTRL, 32'h0);
		wr(OFS_COUNT, 32'h1234_5678);
		wr(OFS_CROUTE, 32'h3C9);
		wr(OFS_CCTRL, 32'h5DD0);
		wr(OFS_STATUS, 32'hFF);
		wr(OFS_MASK, 32'hF0);
		pulse(8'h04);
		rd(8'h54, 32'h1234_5678);
		rd(OFS_STATUS, 32'h20);
		chk(32'(irq), 32'h1);
		pulse(8'h10);
		rd(8'h58, 32'h0);
		pulse(8'h30);
		rd(8'h58, 32'h1234_5678);
		pulse(8'h40);
		rd(OFS_STATUS, 32'hE0);
		rd(8'h5C, 32'h0);
		$display("test capture done");
		// event counting on pin a of channel 0, no match interrupt, reset or stop left armed; output actions stay set
		wr(OFS_MCTRL, 32'h0);
		wr(OFS_STATUS, 32'hFF);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_PRESC, 32'h0);
		wr(OFS_PCOUNT, 32'h0);
		wr(OFS_CTRL, 32'h25);
		repeat (3) pulse(8'h01);
		rd(OFS_COUNT, 32'h3);
		pulse(8'h04);
		rd(OFS_STATUS, 32'h20);
		rd(OFS_COUNT, 32'h3);
		$display("test events done");
		give_verdict();
	end
endmodule // test_tmr_core
